// file: common/iolp_regs.svh
`ifndef IOLP_REGS_SVH
`define IOLP_REGS_SVH

// width of the storage register and of both data buses
`define IOLP_DATA_W 8
// stages in each pin synchroniser
`define IOLP_SYNC_STAGES 3
// storage contents after reset: user lines read back as ones
`define IOLP_LATCH_RST 8'hff
// output enable level while a bus is left undriven
`define IOLP_OE_OFF 1'b1

`endif

// file: common/iolp_pkg.sv
package iolp_pkg;

    // user-side control pins, both active low
    typedef struct packed {
        logic strobe_n;
        logic oe_n;
    } iolp_user_ctl_t;

    // processor-side control pins
    typedef struct packed {
        logic select_n;
        logic write;
        logic read_n;
    } iolp_proc_ctl_t;

    // state of one three-state bus as driven out
    typedef struct packed {
        logic [7:0] data;
        logic oe_n;
    } iolp_bus_drive_t;

endpackage

// file: rtl/iolp_pin_sync.sv
`timescale 1ns/1ps
`include "iolp_regs.svh"

// three-stage pin synchroniser; a bit changes once stages two and three agree
module iolp_pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] s1_q, s2_q, s3_q, q_q;
    logic [W-1:0] s1_d, s2_d, s3_d, q_d;

    // stage one feeds stage two only; the agreement test looks at two and three
    always_comb
    begin
        s1_d = pin_in;
        s2_d = s1_q;
        s3_d = s2_q;
        q_d = q_q;
        for (int i = 0; i < W; i++)
        begin
            if (s2_q[i] == s3_q[i])
            begin
                q_d[i] = s3_q[i];
            end
        end
    end

    // registers only
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            q_q <= RST_VAL;
        end
        else
        begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            q_q <= q_d;
        end
    end

    assign q_out = q_q;
endmodule

// file: rtl/iolp_latch_reg.sv
`timescale 1ns/1ps
`include "iolp_regs.svh"

// the shared storage register; user write wins over processor write
module iolp_latch_reg #(
    parameter int W = `IOLP_DATA_W
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic user_wr_in,
    input wire logic [W-1:0] user_data_in,
    input wire logic proc_wr_in,
    input wire logic [W-1:0] proc_data_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] store_q;
    logic [W-1:0] store_d;

    // next contents by priority; hold when nobody writes
    always_comb
    begin
        store_d = store_q; // [R13]
        if (user_wr_in)
        begin
            store_d = user_data_in; // [R2]
        end
        else if (proc_wr_in)
        begin
            store_d = proc_data_in;
        end
    end

    // reset stands in for the power-up state
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            store_q <= W'(`IOLP_LATCH_RST); // [R4]
        end
        else
        begin
            store_q <= store_d; // [R1]
        end
    end

    assign q_out = store_q;
endmodule

// file: rtl/iolp_port.sv
`timescale 1ns/1ps
`include "iolp_regs.svh"

// Functional notes
// [R1] one 8-bit register, both buses write, read
// [R2] simultaneous writes: user data stored
// [R3] select high idles processor bus only
// [R4] after reset user ones, processor bus floating
// [R5] user bus driven on enable low, strobe high
// [R6] user strobe low captures while master clock high
// [R7] user strobe low blocks processor writes
// [R8] processor read drives contents on its bus
// [R9] processor write stores bus when clock high
// [R10] cross-port read returns inverted value
// [R11] same-port read returns unchanged value
// [R12] processor lines active low, user lines high
// [R13] no write keeps stored value
module iolp_port #(
    parameter int W = `IOLP_DATA_W
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic master_clock_in,
    input wire logic master_select_n_in,
    input wire logic write_command_in,
    input wire logic read_command_n_in,
    input wire logic user_input_strobe_n_in,
    input wire logic user_output_enable_n_in,
    input wire logic [W-1:0] user_data_lines_in,
    input wire logic [W-1:0] processor_bus_lines_in,
    output logic [W-1:0] user_data_lines_out,
    output logic user_data_lines_oe_n_out,
    output logic [W-1:0] processor_bus_lines_out,
    output logic processor_bus_lines_oe_n_out
);
    iolp_pkg::iolp_user_ctl_t user_ctl_raw;
    iolp_pkg::iolp_user_ctl_t user_ctl;
    iolp_pkg::iolp_proc_ctl_t proc_ctl_raw;
    iolp_pkg::iolp_proc_ctl_t proc_ctl;
    logic mclk_s;
    logic [W-1:0] ud_s;
    logic [W-1:0] iv_s;
    logic [W-1:0] latch_q;
    logic user_wr;
    logic proc_wr;
    logic user_drive;
    logic proc_drive;
    iolp_pkg::iolp_bus_drive_t ud_q, ud_d;
    iolp_pkg::iolp_bus_drive_t iv_q, iv_d;

    assign user_ctl_raw.strobe_n = user_input_strobe_n_in;
    assign user_ctl_raw.oe_n = user_output_enable_n_in;
    assign proc_ctl_raw.select_n = master_select_n_in;
    assign proc_ctl_raw.write = write_command_in;
    assign proc_ctl_raw.read_n = read_command_n_in;

    // every pin comes from outside the clock domain
    iolp_pin_sync #(
        .W(2),
        .RST_VAL(2'b11)
    ) u_user_ctl_sync (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .pin_in(user_ctl_raw),
        .q_out(user_ctl)
    );

    // processor controls settle idle: select high, write low, read high
    iolp_pin_sync #(
        .W(3),
        .RST_VAL(3'b101)
    ) u_proc_ctl_sync (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .pin_in(proc_ctl_raw),
        .q_out(proc_ctl)
    );

    // master clock is just a sampled level here, not a clock
    iolp_pin_sync #(
        .W(1),
        .RST_VAL(1'b0)
    ) u_mclk_sync (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .pin_in(master_clock_in),
        .q_out(mclk_s)
    );

    // data lines; bits may settle on different cycles, so hold data
    // stable well before the master clock rises
    iolp_pin_sync #(
        .W(W),
        .RST_VAL('0)
    ) u_ud_sync (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .pin_in(user_data_lines_in),
        .q_out(ud_s)
    );

    iolp_pin_sync #(
        .W(W),
        .RST_VAL('1)
    ) u_iv_sync (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .pin_in(processor_bus_lines_in),
        .q_out(iv_s)
    );

    // write qualifiers; writes repeat each cycle the master clock is high,
    // which mimics a transparent latch closing on the falling edge
    assign user_wr = !user_ctl.strobe_n && mclk_s; // [R6]
    assign proc_wr = !proc_ctl.select_n && proc_ctl.write && mclk_s
        && user_ctl.strobe_n; // [R9] [R7] [R3]

    // the register holds user polarity; processor data enters inverted
    iolp_latch_reg #(
        .W(W)
    ) u_latch (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .user_wr_in(user_wr),
        .user_data_in(ud_s),
        .proc_wr_in(proc_wr),
        .proc_data_in(~iv_s), // [R10] [R12]
        .q_out(latch_q)
    );

    // bus drive decisions; select never gates the user side
    assign user_drive = user_ctl.strobe_n && !user_ctl.oe_n; // [R5] [R3]
    assign proc_drive = !proc_ctl.select_n && !proc_ctl.read_n
        && !proc_ctl.write; // [R8] [R3]

    // next state of both output buses
    always_comb
    begin
        ud_d.data = latch_q; // [R11] [R12]
        ud_d.oe_n = !user_drive; // [R5]
        iv_d.data = ~latch_q; // [R10] [R11] [R12]
        iv_d.oe_n = !proc_drive; // [R8]
    end

    // outputs straight from flops; both buses float during reset
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            ud_q.data <= W'(`IOLP_LATCH_RST); // [R4]
            ud_q.oe_n <= `IOLP_OE_OFF;
            iv_q.data <= ~W'(`IOLP_LATCH_RST);
            iv_q.oe_n <= `IOLP_OE_OFF; // [R4]
        end
        else
        begin
            ud_q <= ud_d;
            iv_q <= iv_d;
        end
    end

    assign user_data_lines_out = ud_q.data;
    assign user_data_lines_oe_n_out = ud_q.oe_n;
    assign processor_bus_lines_out = iv_q.data;
    assign processor_bus_lines_oe_n_out = iv_q.oe_n;

    // checks on the synchronised view of the pins
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);

    reset_state_a: assert property ( // [R4]
        $past(srst_in) |-> latch_q == W'(`IOLP_LATCH_RST) && iv_q.oe_n && ud_q.oe_n)
        else $error("state after reset wrong");

    select_idle_proc_a: assert property ( // [R3]
        proc_ctl.select_n |=> iv_q.oe_n && (latch_q == $past(latch_q) || $past(user_wr)))
        else $error("processor bus active while deselected");

    select_free_user_a: assert property ( // [R3]
        proc_ctl.select_n && user_drive |=> !ud_q.oe_n)
        else $error("select affected user bus");

    user_drive_a: assert property ( // [R5]
        user_ctl.strobe_n && !user_ctl.oe_n |=> !ud_q.oe_n && ud_q.data == $past(latch_q))
        else $error("user bus not driven with contents");

    user_float_a: assert property ( // [R5]
        (!user_ctl.strobe_n || user_ctl.oe_n) |=> ud_q.oe_n)
        else $error("user bus driven when it should float");

    user_capture_a: assert property ( // [R6]
        !user_ctl.strobe_n && mclk_s |=> latch_q == $past(ud_s))
        else $error("user data not captured");

    strobe_blocks_a: assert property ( // [R7]
        !user_ctl.strobe_n && !mclk_s |=> latch_q == $past(latch_q))
        else $error("register changed while user strobe low and clock low");

    proc_read_a: assert property ( // [R8]
        proc_drive |=> !iv_q.oe_n && iv_q.data == ~$past(latch_q))
        else $error("processor read not driven");

    proc_write_a: assert property ( // [R9]
        proc_wr |=> latch_q == ~$past(iv_s))
        else $error("processor write not stored");

    // a user write must win even when the processor asks in the same cycle
    user_priority_a: assert property ( // [R2]
        !user_ctl.strobe_n && mclk_s && !proc_ctl.select_n && proc_ctl.write
        |=> latch_q == $past(ud_s))
        else $error("user write lost priority");

    cross_invert_a: assert property ( // [R10]
        !ud_q.oe_n && !iv_q.oe_n |-> ud_q.data == ~iv_q.data)
        else $error("buses not inverted copies");

    hold_value_a: assert property ( // [R13]
        !user_wr && !proc_wr |=> $stable(latch_q))
        else $error("register changed without a write");

    same_port_a: assert property ( // [R11]
        user_wr ##1 (!user_wr && !proc_wr) [*2] |=> ud_q.data == $past(ud_s, 3))
        else $error("user readback differs");

    // the strobe must shut the processor write path, not just outrank it
    strobe_gate_a: assert property ( // [R7]
        !user_ctl.strobe_n |-> !proc_wr)
        else $error("processor write open while user strobe low");

    // deselected processor side may neither write nor drive
    select_gate_a: assert property ( // [R3]
        proc_ctl.select_n |-> !proc_wr && !proc_drive)
        else $error("processor path active while deselected");

    // full write qualifier built from the pins, independent of proc_wr
    proc_qual_a: assert property ( // [R9]
        !proc_ctl.select_n && proc_ctl.write && mclk_s && user_ctl.strobe_n
        |=> latch_q == ~$past(iv_s))
        else $error("qualified processor write not stored");

    // processor readback of its own write comes back as written
    proc_same_port_a: assert property ( // [R11]
        proc_wr ##1 (!user_wr && !proc_wr) [*2] |=> iv_q.data == $past(iv_s, 3))
        else $error("processor readback differs");

    // processor write seen from the user side arrives inverted
    proc_cross_a: assert property ( // [R10]
        proc_wr ##1 (!user_wr && !proc_wr) [*2] |=> ud_q.data == ~$past(iv_s, 3))
        else $error("processor write not inverted on user bus");

    // user write seen from the processor side arrives inverted
    user_cross_a: assert property ( // [R10]
        user_wr ##1 (!user_wr && !proc_wr) [*2] |=> iv_q.data == ~$past(ud_s, 3))
        else $error("user write not inverted on processor bus");

    // with the master clock low nothing may reach the register
    clock_gate_a: assert property ( // [R6] [R9] [R13]
        !mclk_s |=> $stable(latch_q))
        else $error("register changed with master clock low");

    // any control that is not a read must release the processor bus
    proc_release_a: assert property ( // [R8]
        proc_ctl.select_n || proc_ctl.read_n || proc_ctl.write |=> iv_q.oe_n)
        else $error("processor bus driven without a read");

    // read decode written out from the pins
    proc_read_pins_a: assert property ( // [R8]
        !proc_ctl.select_n && !proc_ctl.read_n && !proc_ctl.write
        |=> !iv_q.oe_n && iv_q.data == ~$past(latch_q))
        else $error("processor read decode wrong");

    // wire levels after reset: user side ones, processor side inverted ones
    reset_data_a: assert property ( // [R4]
        $past(srst_in) |-> ud_q.data == W'(`IOLP_LATCH_RST)
        && iv_q.data == ~W'(`IOLP_LATCH_RST))
        else $error("bus data after reset wrong");

    // two idle cycles leave the data on both output buses frozen
    idle_outputs_a: assert property ( // [R13]
        (!user_wr && !proc_wr) [*2] |=> $stable(ud_q.data) && $stable(iv_q.data))
        else $error("bus data moved without a write");

    // deselection must not stop a user capture
    select_user_a: assert property ( // [R3]
        proc_ctl.select_n && !user_ctl.strobe_n && mclk_s |=> latch_q == $past(ud_s))
        else $error("select blocked a user write");

    // a processor bus in output mode can never be written at the same time
    proc_dir_a: assert property ( // [R8] [R9]
        proc_drive |-> !proc_wr)
        else $error("processor bus read and written together");

    // the user bus is never driven while it is being captured
    user_dir_a: assert property ( // [R5] [R6]
        user_drive |-> !user_wr)
        else $error("user bus driven during capture");

    // every change of the register comes from one of the two ports
    latch_source_a: assert property ( // [R1]
        $changed(latch_q) |-> ($past(user_wr) && latch_q == $past(ud_s))
        || ($past(proc_wr) && latch_q == ~$past(iv_s)))
        else $error("register changed from no port");

    // main scenarios; windows sized for the synchroniser delay on the read pins
    user_write_c: cover property (user_wr ##1 !user_wr ##[1:30] !ud_q.oe_n);
    proc_write_c: cover property (proc_wr ##[1:30] !iv_q.oe_n);
    proc_to_user_c: cover property (proc_wr ##1 !proc_wr ##[1:30] !ud_q.oe_n);
    both_read_c: cover property (!ud_q.oe_n && !iv_q.oe_n);
    contention_c: cover property (!user_ctl.strobe_n && !proc_ctl.select_n
        && proc_ctl.write && mclk_s);
endmodule

// file: test/iolp_bus_partner.sv
`timescale 1ns/1ps

// far-side party on one three-state bus, resolving the wire level
module iolp_bus_partner #(
    parameter int W = 8
) (
    input wire logic clk_in,
    input wire iolp_pkg::iolp_bus_drive_t dut_drv_in,
    input wire logic [W-1:0] far_val_in,
    input wire logic far_en_in,
    output logic [W-1:0] wire_out
);
    logic [W-1:0] last_q;

    // no pull on these lines: a floating bus shows the inverse of its last level
    always_comb
    begin
        if (!dut_drv_in.oe_n && far_en_in)
            wire_out = 'x; // contention is never legal
        else if (!dut_drv_in.oe_n)
            wire_out = dut_drv_in.data; // three-state, driven by the port
        else if (far_en_in)
            wire_out = far_val_in; // far side drives its own polarity
        else
            wire_out = ~last_q;
    end

    // remember the last level so a released bus does not keep it
    always_ff @(posedge clk_in)
    begin
        last_q <= wire_out;
    end
endmodule

// file: test/tb_top.sv
`timescale 1ns/1ps

`define CHK(nm, exp, got) \
    begin cmp_count++; if ((got) !== (exp)) begin errors++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end

module tb_top;
    typedef struct packed {
        logic is_proc;
        logic [7:0] val;
        logic [7:0] exp_u;
        logic [7:0] exp_p;
    } iolp_tb_row_t;

    logic clk_in = 0;
    logic srst_in = 1;
    logic mclk = 0, sel_n = 1, wr = 0, rd_n = 1, strobe_n = 1, uoe_n = 1;
    logic [7:0] ud_drv = 8'h00, pv_drv = 8'h00, ud_wire, pv_wire;
    logic ud_en = 0, pv_en = 0;
    wire iolp_pkg::iolp_bus_drive_t u_drv, p_drv;
    int errors = 0, cmp_count = 0, cycles = 0;
    iolp_tb_row_t rows [5] = '{
        '{1'b0, 8'h5a, 8'h5a, 8'ha5}, '{1'b0, 8'h00, 8'h00, 8'hff},
        '{1'b1, 8'h3c, 8'hc3, 8'h3c}, '{1'b1, 8'hff, 8'h00, 8'hff},
        '{1'b0, 8'hff, 8'hff, 8'h00}};

    always #4 clk_in = ~clk_in;

    iolp_port u_dut (.clk_in(clk_in), .srst_in(srst_in), .master_clock_in(mclk),
        .master_select_n_in(sel_n), .write_command_in(wr), .read_command_n_in(rd_n),
        .user_input_strobe_n_in(strobe_n), .user_output_enable_n_in(uoe_n),
        .user_data_lines_in(ud_wire), .processor_bus_lines_in(pv_wire),
        .user_data_lines_out(u_drv.data), .user_data_lines_oe_n_out(u_drv.oe_n),
        .processor_bus_lines_out(p_drv.data), .processor_bus_lines_oe_n_out(p_drv.oe_n));
    iolp_bus_partner u_ubus (.clk_in(clk_in), .dut_drv_in(u_drv), .far_val_in(ud_drv),
        .far_en_in(ud_en), .wire_out(ud_wire));
    iolp_bus_partner u_pbus (.clk_in(clk_in), .dut_drv_in(p_drv), .far_val_in(pv_drv),
        .far_en_in(pv_en), .wire_out(pv_wire));

    task report_and_stop();
        if (errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // a hung wait ends the run as a failure
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            report_and_stop();
        end
    end

    // inputs always move 1 ns after a rising edge
    task cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // master clock high long enough for the synchroniser to see it
    task mpulse();
        mclk = 1;
        cyc(4);
        mclk = 0;
        cyc(6);
    endtask

    task uwr(input logic [7:0] v);
        ud_drv = v;
        ud_en = 1;
        strobe_n = 0;
        cyc(6);
        mpulse();
        strobe_n = 1;
        ud_en = 0;
        cyc(2);
    endtask

    task pwr(input logic [7:0] w, input logic s_n);
        pv_drv = w;
        pv_en = 1;
        sel_n = s_n;
        wr = 1;
        cyc(6);
        mpulse();
        wr = 0;
        sel_n = 1;
        pv_en = 0;
        cyc(2);
    endtask

    // read both ports at once, then check both buses float again
    task rd(input logic [7:0] eu, input logic [7:0] ep);
        uoe_n = 0;
        sel_n = 0;
        rd_n = 0;
        cyc(10);
        `CHK("user data", eu, u_drv.data)
        `CHK("user oe_n", 1'b0, u_drv.oe_n)
        `CHK("proc data", ep, p_drv.data)
        `CHK("proc oe_n", 1'b0, p_drv.oe_n)
        uoe_n = 1;
        sel_n = 1;
        rd_n = 1;
        cyc(8);
        `CHK("user idle", 1'b1, u_drv.oe_n)
        `CHK("proc idle", 1'b1, p_drv.oe_n)
    endtask

    initial
    begin
        cyc(10);
        `CHK("rst user oe_n", 1'b1, u_drv.oe_n)
        `CHK("rst proc oe_n", 1'b1, p_drv.oe_n)
        srst_in = 0;
        cyc(2);
        rd(8'hff, 8'h00);
        // ordinary writes through either port, read back through both
        foreach (rows[i])
        begin
            if (rows[i].is_proc)
                pwr(rows[i].val, 1'b0);
            else
                uwr(rows[i].val);
            rd(rows[i].exp_u, rows[i].exp_p);
        end
        // strobe low with master clock low must not store
        ud_drv = 8'h11;
        ud_en = 1;
        strobe_n = 0;
        cyc(12);
        strobe_n = 1;
        ud_en = 0;
        cyc(2);
        rd(8'hff, 8'h00);
        // processor write with select high is ignored, read too
        pwr(8'h22, 1'b1);
        rd(8'hff, 8'h00);
        rd_n = 0;
        cyc(10);
        `CHK("deselected read", 1'b1, p_drv.oe_n)
        rd_n = 1;
        // both ports write together: user data wins
        ud_drv = 8'ha5;
        ud_en = 1;
        strobe_n = 0;
        pv_drv = 8'h0f;
        pv_en = 1;
        sel_n = 0;
        wr = 1;
        cyc(6);
        mpulse();
        {strobe_n, sel_n, wr, ud_en, pv_en} = 5'b11000;
        cyc(2);
        rd(8'ha5, 8'h5a);
        // second reset in mid-run restores the power-up state
        srst_in = 1;
        cyc(10);
        `CHK("rst2 user oe_n", 1'b1, u_drv.oe_n)
        `CHK("rst2 proc oe_n", 1'b1, p_drv.oe_n)
        srst_in = 0;
        cyc(2);
        rd(8'hff, 8'h00);
        report_and_stop();
    end
endmodule
